/* File: logic/doeu_cfg.svh */
// doeu_cfg.svh: timing and layout constants of the discrete output unit
// assumes inclusion by the package and the design file only
`ifndef DOEU_CFG_SVH
`define DOEU_CFG_SVH
`define DOEU_CLK_HZ        50000000
`define DOEU_OUT_NUM       32
`define DOEU_IN_NUM        32
`define DOEU_FLAG_NUM      16
`define DOEU_BANK_W        8
`define DOEU_FPS_X1000_2997 29970
`define DOEU_FPS_X1000_30   30000
`define DOEU_FPS_X1000_23976 23976
`define DOEU_FPS_X1000_24   24000
`define DOEU_FPS_X1000_25   25000
`define DOEU_MAX_FRAMES    255
`endif

/* File: logic/doeu_pkg.sv */
// doeu_pkg: types shared by the discrete output unit
// assumes doeu_cfg.svh is on the include path
`include "doeu_cfg.svh"
package doeu_pkg;
   typedef enum logic [3:0] {
      DOEU_OP_NONE, DOEU_OP_ON, DOEU_OP_OFF, DOEU_OP_TOGGLE,
      DOEU_OP_BLINK, DOEU_OP_PULSE, DOEU_OP_BANK_WR, DOEU_OP_BANK_RD,
      DOEU_OP_FLAG_ON, DOEU_OP_FLAG_OFF, DOEU_OP_FLAG_TOG
   } doeu_op_t;
   typedef enum logic [2:0] {
      DOEU_FPS_2997, DOEU_FPS_30, DOEU_FPS_23976, DOEU_FPS_24, DOEU_FPS_25
   } doeu_fps_t;
   typedef enum {DOEU_ST_STEADY, DOEU_ST_BLINK, DOEU_ST_PULSE} doeu_mode_t;
   typedef struct packed {
      doeu_op_t   op;
      logic [4:0] index;
      logic [1:0] bank;
      logic [7:0] frames;
      logic [7:0] value;
   } doeu_cmd_t;
endpackage : doeu_pkg

/* File: logic/doeu_unit.sv */
// doeu_unit: executes discrete output and flag commands
// assumes one command per valid cycle from the sequence engine,
// synchronous inputs and a free running 50 MHz clock
`timescale 1ns/1ps
`include "doeu_cfg.svh"
module doeu_unit
   import doeu_pkg::*;
#(
   parameter int OUT_NUM  = `DOEU_OUT_NUM,
   parameter int IN_NUM   = `DOEU_IN_NUM,
   parameter int FLAG_NUM = `DOEU_FLAG_NUM
) (
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire logic              cmd_valid_i,
   input  wire doeu_cmd_t         cmd_i,
   input  wire doeu_fps_t         fps_i,
   input  wire logic [IN_NUM-1:0] inputs_i,
   output logic [OUT_NUM-1:0]     outputs_o,
   output logic [FLAG_NUM-1:0]    flags_o,
   output logic [7:0]             rd_data_o,
   output logic                   rd_valid_o,
   output logic                   frame_tick_o
);
   initial begin
      if (OUT_NUM != 32 || IN_NUM != 32 || FLAG_NUM < 1 || FLAG_NUM > 32)
         $error("doeu_unit: unsupported sizes");
   end

   // clocks per frame, scaled by 1000 for fractional rates
   localparam longint CLK_X1000 = longint'(`DOEU_CLK_HZ) * 1000;
   localparam logic [21:0] DIV_2997  = 22'(CLK_X1000 / `DOEU_FPS_X1000_2997);
   localparam logic [21:0] DIV_30    = 22'(CLK_X1000 / `DOEU_FPS_X1000_30);
   localparam logic [21:0] DIV_23976 = 22'(CLK_X1000 / `DOEU_FPS_X1000_23976);
   localparam logic [21:0] DIV_24    = 22'(CLK_X1000 / `DOEU_FPS_X1000_24);
   localparam logic [21:0] DIV_25    = 22'(CLK_X1000 / `DOEU_FPS_X1000_25);

   wire logic [21:0] frame_div =
      (fps_i == DOEU_FPS_2997)  ? DIV_2997  :
      (fps_i == DOEU_FPS_30)    ? DIV_30    :
      (fps_i == DOEU_FPS_23976) ? DIV_23976 :
      (fps_i == DOEU_FPS_24)    ? DIV_24    : DIV_25;

   logic [21:0] div_cnt_r;
   wire logic   tick = (div_cnt_r >= frame_div - 22'h1);

   // one frame tick shared by all timers
   always_ff @(posedge clk_i) begin
      if (srst_i || tick) div_cnt_r <= 22'h0;
      else                div_cnt_r <= div_cnt_r + 22'h1;
   end
   assign frame_tick_o = tick;

   // command decode
   wire logic       is_cmd   = cmd_valid_i;
   wire logic [4:0] bank_lo  = {cmd_i.bank, 3'h0};
   wire logic [7:0] frames_c = (cmd_i.frames == 8'h0) ? 8'h1 : cmd_i.frames;

   doeu_mode_t  mode_r   [OUT_NUM];
   logic [7:0]  period_r [OUT_NUM];
   logic [7:0]  cnt_r    [OUT_NUM];
   logic [OUT_NUM-1:0] out_r;

   genvar g;
   generate
      for (g = 0; g < OUT_NUM; g++) begin : g_out
         wire logic hit  = is_cmd && (cmd_i.index == 5'(g));
         wire logic bhit = is_cmd && (cmd_i.op == DOEU_OP_BANK_WR) &&
                           (bank_lo == 5'(g & ~7));
         wire logic expire = tick && (cnt_r[g] <= 8'h1);
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               out_r[g]    <= 1'b0;
               mode_r[g]   <= DOEU_ST_STEADY;
               period_r[g] <= 8'h0;
               cnt_r[g]    <= 8'h0;
            end else if (bhit) begin
               // byte bit g%8 to output; cancels timing
               out_r[g]  <= cmd_i.value[g % 8];
               mode_r[g] <= DOEU_ST_STEADY;
            end else if (hit && cmd_i.op == DOEU_OP_ON) begin
               out_r[g]  <= 1'b1;
               mode_r[g] <= DOEU_ST_STEADY;
            end else if (hit && cmd_i.op == DOEU_OP_OFF) begin
               out_r[g]  <= 1'b0;
               mode_r[g] <= DOEU_ST_STEADY;
            end else if (hit && cmd_i.op == DOEU_OP_TOGGLE) begin
               out_r[g]  <= ~out_r[g];
               mode_r[g] <= DOEU_ST_STEADY;
            end else if (hit && cmd_i.op == DOEU_OP_BLINK) begin
               out_r[g]    <= ~out_r[g];
               mode_r[g]   <= DOEU_ST_BLINK;
               period_r[g] <= frames_c;
               cnt_r[g]    <= frames_c;
            end else if (hit && cmd_i.op == DOEU_OP_PULSE) begin
               // invert for the pulse, restore later
               out_r[g]  <= ~out_r[g];
               mode_r[g] <= DOEU_ST_PULSE;
               cnt_r[g]  <= frames_c;
            end else begin
               case (mode_r[g])
                  DOEU_ST_BLINK: begin
                     if (expire) begin
                        out_r[g] <= ~out_r[g];
                        cnt_r[g] <= period_r[g];
                     end else if (tick) cnt_r[g] <= cnt_r[g] - 8'h1;
                  end
                  DOEU_ST_PULSE: begin
                     if (expire) begin
                        out_r[g]  <= ~out_r[g];
                        mode_r[g] <= DOEU_ST_STEADY;
                     end else if (tick) cnt_r[g] <= cnt_r[g] - 8'h1;
                  end
                  DOEU_ST_STEADY: ;
                  default: mode_r[g] <= DOEU_ST_STEADY;
               endcase
            end
         end
      end
   endgenerate
   assign outputs_o = out_r;

   logic [FLAG_NUM-1:0] flag_r;
   wire logic [FLAG_NUM-1:0] flag_sel =
      FLAG_NUM'({{(32-1){1'b0}}, 1'b1} << cmd_i.index);
   always_ff @(posedge clk_i) begin
      if (srst_i) flag_r <= '0;
      else if (is_cmd && cmd_i.op == DOEU_OP_FLAG_ON)  flag_r <= flag_r | flag_sel;
      else if (is_cmd && cmd_i.op == DOEU_OP_FLAG_OFF) flag_r <= flag_r & ~flag_sel;
      else if (is_cmd && cmd_i.op == DOEU_OP_FLAG_TOG) flag_r <= flag_r ^ flag_sel;
   end
   assign flags_o = flag_r;

   // bank read, lowest input in LSB
   wire logic [7:0] rd_byte = inputs_i[bank_lo +: 8];
   wire logic       rd_go   = is_cmd && cmd_i.op == DOEU_OP_BANK_RD;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rd_data_o  <= 8'h0;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_go;
         if (rd_go) rd_data_o <= rd_byte;
      end
   end

   // on command drives output next cycle
   out_on_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_ON |=> outputs_o[$past(cmd_i.index)])
      else $error("on did not drive output");
   out_toggle_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_TOGGLE |=>
      outputs_o[$past(cmd_i.index)] != $past(outputs_o[cmd_i.index]))
      else $error("toggle did not invert");
   bank_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_BANK_RD |=>
      rd_valid_o && rd_data_o == $past(rd_byte))
      else $error("bank read mismatch");
   bank_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_BANK_WR |=>
      outputs_o[$past(bank_lo) +: 8] == $past(cmd_i.value))
      else $error("bank write mismatch");
   // flag on sets flag
   // flag indices of FLAG_NUM and up are ignored, so they are left out here
   flag_on_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_FLAG_ON && flag_sel != '0 |=>
      (flags_o & $past(flag_sel)) != '0)
      else $error("flag not set");
   flag_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_FLAG_OFF |=>
      (flags_o & $past(flag_sel)) == '0)
      else $error("flag not cleared");
   tick_gap_a: assert property (@(posedge clk_i) disable iff (srst_i)
      tick |=> !tick)
      else $error("frame tick too frequent");
   out_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_OFF |=> !outputs_o[$past(cmd_i.index)])
      else $error("off did not clear output");
   flag_tog_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_FLAG_TOG |=>
      (flags_o & $past(flag_sel)) == (~$past(flags_o) & $past(flag_sel)))
      else $error("flag toggle did not invert");
   blink_cancel_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_ON |=>
      mode_r[$past(cmd_i.index)] == DOEU_ST_STEADY)
      else $error("blink not cancelled");
   // pulse starts with the opposite level
   pulse_start_a: assert property (@(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_i.op == DOEU_OP_PULSE |=>
      outputs_o[$past(cmd_i.index)] != $past(outputs_o[cmd_i.index]))
      else $error("pulse did not invert output");
endmodule : doeu_unit

/* File: tb/doeu_field.sv */
// doeu_field: discrete input lines seen by the unit
// assumes the bench sets the contact pattern; 1 means a closed contact
`timescale 1ns/1ps
module doeu_field (
   input  wire logic [31:0] contacts_i,
   output logic [31:0]      inputs_o
);
   assign inputs_o = contacts_i;
endmodule : doeu_field

/* File: tb/test_discrete_output_event_unit.sv */
// test_discrete_output_event_unit: self-checking bench of doeu_unit
// assumes a 50 MHz clock; a run never reaches the first frame tick
`timescale 1ns/1ps
module test_discrete_output_event_unit import doeu_pkg::*;;
   typedef struct packed {
      logic [31:0] o;
      logic [15:0] f;
      logic [7:0]  r;
      logic        v;
   } doeu_exp_t;
   logic        clk_i = 0, srst_i = 1, cmd_valid_i = 0, seen_r = 0;
   doeu_cmd_t   cmd_i = '0;
   doeu_fps_t   fps_i = DOEU_FPS_30;
   logic [31:0] contacts = '0, inputs_i, outputs_o, exp_o = '0;
   logic [15:0] flags_o, exp_f = '0;
   logic [7:0]  rd_data_o, exp_r = '0;
   logic        rd_valid_o;
   doeu_exp_t   notes[$], n;
   int          miscompares = 0, checked = 0, i, k;
   doeu_op_t    op;
   doeu_unit doeu_unit_i (.clk_i(clk_i), .srst_i(srst_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .fps_i(fps_i),
      .inputs_i(inputs_i), .outputs_o(outputs_o), .flags_o(flags_o),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .frame_tick_o());
   doeu_field doeu_field_i (.contacts_i(contacts), .inputs_o(inputs_i));
   initial forever #10 clk_i = ~clk_i;
   task check(string what, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task tally_and_finish;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // note the expectation, then strobe one command for one cycle
   task send(doeu_op_t o, int idx, int frm, int val);
      @(negedge clk_i);
      cmd_i = '{op: o, index: idx[4:0], bank: idx[1:0],
                frames: frm[7:0], value: val[7:0]};
      cmd_valid_i = 1;
      notes.push_back('{exp_o, exp_f, exp_r, o == DOEU_OP_BANK_RD});
      @(negedge clk_i);
      cmd_valid_i = 0;
   endtask : send
   always @(posedge clk_i) seen_r <= cmd_valid_i;
   // results land one edge after the command is taken
   always @(negedge clk_i) if (seen_r) begin
      n = notes.pop_front();
      check("outputs", outputs_o, n.o);
      check("flags", {16'h0000, flags_o}, {16'h0000, n.f});
      check("rd_valid", {31'h0, rd_valid_o}, {31'h0, n.v});
      check("rd_data", {24'h0, rd_data_o}, {24'h0, n.r});
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      miscompares++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'h300A));
      repeat (3) @(posedge clk_i);
      @(negedge clk_i) srst_i = 0;
      check("reset outputs", outputs_o, 32'h0000_0000);
      for (k = 0; k < 16; k++) begin
         i = $urandom_range(31);
         op = doeu_op_t'($urandom_range(3, 1));
         exp_o[i] = op == DOEU_OP_ON || (op == DOEU_OP_TOGGLE && !exp_o[i]);
         send(op, i, 0, 0);
      end
      $display("test steady outputs done");
      for (k = 0; k < 4; k++) begin
         i = (k == 0) ? 157 : $urandom_range(255);
         exp_o[8*k +: 8] = i[7:0];
         send(DOEU_OP_BANK_WR, k, 0, i);
      end
      $display("test bank write done");
      for (k = 0; k < 4; k++) begin
         contacts = $urandom;
         exp_r = contacts[8*k +: 8];
         send(DOEU_OP_BANK_RD, k, 0, 0);
      end
      $display("test bank read done");
      // flags; index 16 and up is ignored
      for (k = 0; k < 20; k++) begin
         i = $urandom_range(19);
         op = doeu_op_t'($urandom_range(10, 8));
         if (i < 16) exp_f[i] = op == DOEU_OP_FLAG_ON ||
            (op == DOEU_OP_FLAG_TOG && !exp_f[i]);
         send(op, i, 0, 0);
      end
      $display("test flags done");
      // pulse both levels across the frame rates, one level per rate
      for (k = 0; k < 5; k++) begin
         fps_i = doeu_fps_t'(k);
         exp_o[k+3] = k[0];
         send(k[0] ? DOEU_OP_ON : DOEU_OP_OFF, k + 3, 0, 0);
         exp_o[k+3] = !k[0];
         send(DOEU_OP_PULSE, k + 3, $urandom_range(255, 1), 0);
      end
      $display("test pulse done");
      // blink starts inverted, then on and bank write cancel
      exp_o[9] = !exp_o[9];
      send(DOEU_OP_BLINK, 9, 2, 0);
      exp_o[9] = 1;
      send(DOEU_OP_ON, 9, 0, 0);
      exp_o[10] = !exp_o[10];
      send(DOEU_OP_BLINK, 10, 1, 0);
      exp_o[15:8] = 8'hA5;
      send(DOEU_OP_BANK_WR, 1, 0, 8'hA5);
      repeat (200) @(negedge clk_i);
      check("held outputs", outputs_o, exp_o);
      check("notes left", notes.size(), 0);
      $display("test blink done");
      tally_and_finish;
   end
endmodule : test_discrete_output_event_unit
